// >>> bench/rscr_strap_board.sv
// rscr_strap_board: board logic driving ratio straps and the platform clock
// assumes hold_i stays high through reset until the device has locked
`timescale 1ns/100ps
module rscr_strap_board
  import rscr_pkg::*;
(
  input wire logic clk_i,
  input wire logic hold_i,
  input wire logic [3:0] plat_code_i,
  input wire logic [4:0] core_code_i,
  output logic [3:0] plat_o,
  output logic [3:0] core_upper_o,
  output logic core_lsb_o,
  output logic pclk_o
);
  logic [2:0] phase_reg = 3'h0; // platform clock phase, one writer only
  // platform clock at an eighth of the system rate, free running
  always_ff @(posedge clk_i)
    phase_reg <= phase_reg + 3'h1;
  assign pclk_o = phase_reg[2];
  // every strap bit driven while held; once let go the lines wander each cycle
  always_ff @(posedge clk_i)
  begin
    if (hold_i)
    begin
      plat_o <= plat_code_i;
      {core_upper_o, core_lsb_o} <= core_code_i;
    end
    else
    begin
      plat_o <= ~plat_o;
      {core_upper_o, core_lsb_o} <= ~{core_upper_o, core_lsb_o};
    end
  end
endmodule

// >>> bench/rscr_top_props.sv
// rscr_top_props: port checks for the strap ratio selector
// assumes bind into rscr_top, platform clock of eight system cycles, enable only
// dropped after lock and followed by a reset before it rises again
`timescale 1ns/100ps
module rscr_top_props
  import rscr_pkg::*;
#(
  parameter int DIV_W = 8,
  parameter int SETTLE_CYC = 8
)(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [3:0] platform_ratio_straps_i,
  input wire logic [3:0] core_ratio_strap_upper_i,
  input wire logic core_ratio_strap_lsb_i,
  input wire logic platform_clk_i,
  input wire logic [DIV_W-1:0] local_bus_divider_field_i,
  input wire logic [3:0] plat_mult_o,
  input wire logic [3:0] core_half_o,
  input wire logic cfg_valid_o,
  input wire logic cfg_error_o,
  input wire logic mem_bus_clk_o,
  input wire logic [2:0] local_bus_clock_outputs_o
);
  // one domain, so clock and reset are set once
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);
  a_result_exclusive: assert property (!(cfg_valid_o && cfg_error_o))
    else $error("valid and error both high");
  a_valid_holds: assert property (cfg_valid_o |=> cfg_valid_o)
    else $error("valid dropped without reset");
  a_error_holds: assert property (cfg_error_o |=> cfg_error_o)
    else $error("error dropped without reset");
  a_ratios_frozen: assert property (
    cfg_valid_o |=> $stable(plat_mult_o) && $stable(core_half_o))
    else $error("ratio moved after lock");
  a_mult_legal: assert property (
    cfg_valid_o |-> plat_mult_o inside {[4'h2:4'h6], 4'h8, 4'h9})
    else $error("multiplier outside table");
  a_core_legal: assert property (cfg_valid_o |-> core_half_o inside {[4'h4:4'h9]})
    else $error("core ratio outside table");
  a_error_quiet: assert property (
    cfg_error_o |-> !mem_bus_clk_o && local_bus_clock_outputs_o == 3'h0)
    else $error("clock runs on bad straps");
  a_mem_gated: assert property (!cfg_valid_o |-> !mem_bus_clk_o)
    else $error("memory clock before lock");
  a_mem_half_rate: assert property (
    $changed(mem_bus_clk_o) && cfg_valid_o |=> $stable(mem_bus_clk_o) [*7])
    else $error("memory clock not half platform");
  a_lb_bits_equal: assert property (local_bus_clock_outputs_o inside {3'h0, 3'h7})
    else $error("local clock outputs differ");
  // enable low must freeze valid and both bus clock outputs for the following edge
  a_enable_freeze: assert property (
    !ce_i |=> $stable(cfg_valid_o) && $stable(mem_bus_clk_o)
      && $stable(local_bus_clock_outputs_o))
    else $error("output moved with enable low");
endmodule
bind rscr_top rscr_top_props #(.DIV_W(DIV_W), .SETTLE_CYC(SETTLE_CYC)) u_props (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
  .platform_ratio_straps_i(platform_ratio_straps_i), .platform_clk_i(platform_clk_i),
  .core_ratio_strap_upper_i(core_ratio_strap_upper_i),
  .core_ratio_strap_lsb_i(core_ratio_strap_lsb_i),
  .local_bus_divider_field_i(local_bus_divider_field_i), .plat_mult_o(plat_mult_o),
  .core_half_o(core_half_o), .cfg_valid_o(cfg_valid_o), .cfg_error_o(cfg_error_o),
  .mem_bus_clk_o(mem_bus_clk_o), .local_bus_clock_outputs_o(local_bus_clock_outputs_o));

// >>> bench/rscr_top_tb_top.sv
// rscr_top_tb_top: strap decode, refusal after lock and clock ratio tests
// assumes the board model sets straps and an eight cycle platform clock
`timescale 1ns/100ps
`define CHK(a, b) \
  begin \
    n_checks++; \
    if ((a) !== (b)) \
    begin \
      failures++; \
      $display("wrong value at %0t: %0h not %0h", $time, a, b); \
    end \
  end
module rscr_top_tb_top
  import rscr_pkg::*;
;
  logic sys_clk_i = 1'b0, nrst_i = 1'b0, hold = 1'b1, ce = 1'b1, valid, err, mem, lsb, pclk;
  logic [3:0] plat_code = 4'h2, straps, upper, mult, half;
  logic [4:0] core_code = 5'h08;
  logic [7:0] div = 8'h04;
  logic [2:0] lb;
  logic [3:0] plats [7] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9};
  logic [4:0] cores [6] = '{5'h08, 5'h0C, 5'h10, 5'h1C, 5'h14, 5'h0E};
  int failures = 0, n_checks = 0;
  // clock at 50 MHz
  initial
  begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  rscr_strap_board u_board (.clk_i(sys_clk_i), .hold_i(hold), .plat_code_i(plat_code),
    .core_code_i(core_code), .plat_o(straps), .core_upper_o(upper), .core_lsb_o(lsb),
    .pclk_o(pclk));
  // short settle count keeps the many resets cheap
  rscr_top #(.SETTLE_CYC(2)) uut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(ce),
    .platform_ratio_straps_i(straps), .core_ratio_strap_upper_i(upper),
    .core_ratio_strap_lsb_i(lsb), .platform_clk_i(pclk), .local_bus_divider_field_i(div),
    .plat_mult_o(mult), .core_half_o(half), .cfg_valid_o(valid), .cfg_error_o(err),
    .mem_bus_clk_o(mem), .local_bus_clock_outputs_o(lb));
  // expected multiplier, zero for reserved or missing codes
  function automatic logic [3:0] exp_mult(input logic [3:0] c);
    return (c inside {4'h0, 4'h1, 4'h7} || c > 4'h9) ? 4'h0 : c;
  endfunction
  // expected core ratio in half steps, zero when unlisted
  function automatic logic [3:0] exp_half(input logic [4:0] c);
    case (c)
      5'h08: return 4'h4;
      5'h0C: return 4'h5;
      5'h10: return 4'h6;
      5'h1C: return 4'h7;
      5'h14: return 4'h8;
      5'h0E: return 4'h9;
      default: return 4'h0;
    endcase
  endfunction
  // reset with given straps, wait for lock, let straps wander, then check
  task automatic boot(input logic [3:0] p, input logic [4:0] c);
    int k;
    logic e;
    @(posedge sys_clk_i);
    plat_code <= p;
    core_code <= c;
    hold <= 1'b1;
    nrst_i <= 1'b0;
    ce <= 1'b1; // enable comes back only while reset is held
    repeat (5) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    for (k = 0; k < 40 && valid !== 1'b1 && err !== 1'b1; k++)
      @(posedge sys_clk_i);
    @(posedge sys_clk_i);
    hold <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    #1;
    e = exp_mult(p) === 4'h0 || exp_half(c) === 4'h0;
    `CHK(err, e)
    `CHK(valid, !e)
    if (!e)
    begin
      `CHK(mult, exp_mult(p))
      `CHK(half, exp_half(c))
    end
  endtask
  // cycles between two rising edges of the chosen clock
  task automatic measure(input bit sel, output int n);
    logic prev, cur;
    int k;
    n = 0;
    k = 0;
    prev = 1'b1;
    while (k < 2 && n < 3000)
    begin
      @(posedge sys_clk_i);
      #1;
      cur = sel ? lb[0] : mem;
      if (k == 1)
        n++;
      if (cur && !prev)
        k++;
      prev = cur;
    end
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    int n;
    logic [7:0] d;
    logic m;
    logic [2:0] l;
    void'($urandom(32'hEDC0));
    for (int i = 0; i < 16; i++)
      boot(4'(i), cores[$urandom_range(5)]);
    $display("platform code sweep done");
    for (int i = 0; i < 32; i++)
      boot(plats[$urandom_range(6)], 5'(i));
    $display("core code sweep done");
    boot(4'h4, 5'h10);
    for (int i = 0; i < 6; i++)
    begin
      d = i < 4 ? 8'(i) : 8'($urandom_range(12, 4));
      @(posedge sys_clk_i);
      div <= d;
      measure(1'b1, n);
      measure(1'b1, n);
      `CHK(n, ((d < 8'h02) ? 2 : int'(d)) * 8)
    end
    measure(1'b0, n);
    `CHK(n, 16)
    $display("clock ratio test done");
    // enable low: clocks must stop where they stand for longer than a half period
    @(posedge sys_clk_i);
    ce <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    m = mem;
    l = lb;
    repeat (100) @(posedge sys_clk_i);
    #1;
    `CHK(mem, m)
    `CHK(lb, l)
    `CHK(valid, 1'b1)
    // reset while frozen, so no odd platform tick follows the freeze
    boot(4'h2, 5'h08);
    $display("clock enable test done");
    conclude();
  end
  // watchdog well beyond the few thousand cycles the tests need
  initial
  begin
    repeat (50000) @(posedge sys_clk_i);
    failures++;
    conclude();
  end
endmodule

// >>> hdl/rscr_clkdiv.sv
// rscr_clkdiv: integer divider producing a registered divided-clock level
// assumes enable pulses are on the same clock; ratio below two acts as two
`timescale 1ns/100ps
module rscr_clkdiv
  import rscr_pkg::*;
#(
  parameter int W = 8
)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic run_i,
  input wire logic [W-1:0] ratio_i,
  output logic clk_o
);

  logic [W-1:0] cnt_reg; // ticks since last edge
  logic [W-1:0] half_lo; // low half of the ratio
  logic [W-1:0] half_hi; // high half, takes the odd tick
  logic [W-1:0] lim;

  // odd ratios keep the low half shorter by one tick
  always_comb
  begin
    lim = (ratio_i < W'(2)) ? W'(2) : ratio_i;
    half_lo = lim >> 1;
    half_hi = lim - half_lo;
  end

  // divider count and output toggle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_reg <= '0;
      clk_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!run_i)
      begin
        cnt_reg <= '0;
        clk_o <= 1'b0;
      end
      else if (tick_i)
      begin
        if (cnt_reg + W'(1) >= (clk_o ? half_hi : half_lo))
        begin
          cnt_reg <= '0;
          clk_o <= ~clk_o;
        end
        else
          cnt_reg <= cnt_reg + W'(1);
      end
    end
  end

endmodule

// >>> hdl/rscr_pkg.sv
// rscr_pkg: constants, codes and carrier types for the strap-driven clock ratio selector
// assumes a single 50 MHz system clock and straps that settle during power-up reset
package rscr_pkg;

  // strap and divider field widths
  localparam int RSCR_PLAT_W = 4;
  localparam int RSCR_CORE_W = 5;
  localparam int RSCR_DIV_W = 8;

  // platform:reference multiplier codes
  localparam logic [3:0] RSCR_PLAT_X2 = 4'h2;
  localparam logic [3:0] RSCR_PLAT_X3 = 4'h3;
  localparam logic [3:0] RSCR_PLAT_X4 = 4'h4;
  localparam logic [3:0] RSCR_PLAT_X5 = 4'h5;
  localparam logic [3:0] RSCR_PLAT_X6 = 4'h6;
  localparam logic [3:0] RSCR_PLAT_X8 = 4'h8;
  localparam logic [3:0] RSCR_PLAT_X9 = 4'h9;

  // core:platform ratio codes, ratio held in half steps
  localparam logic [4:0] RSCR_CORE_2P0 = 5'h08;
  localparam logic [4:0] RSCR_CORE_2P5 = 5'h0C;
  localparam logic [4:0] RSCR_CORE_3P0 = 5'h10;
  localparam logic [4:0] RSCR_CORE_3P5 = 5'h1C;
  localparam logic [4:0] RSCR_CORE_4P0 = 5'h14;
  localparam logic [4:0] RSCR_CORE_4P5 = 5'h0E;

  // ratio values in half steps (2.0 = 4 half steps)
  localparam logic [3:0] RSCR_HALF_2P0 = 4'h4;
  localparam logic [3:0] RSCR_HALF_2P5 = 4'h5;
  localparam logic [3:0] RSCR_HALF_3P0 = 4'h6;
  localparam logic [3:0] RSCR_HALF_3P5 = 4'h7;
  localparam logic [3:0] RSCR_HALF_4P0 = 4'h8;
  localparam logic [3:0] RSCR_HALF_4P5 = 4'h9;

  // memory bus divides platform by this
  localparam logic [1:0] RSCR_MEM_DIV = 2'h2;

  // frequency limits in MHz
  localparam int RSCR_MEM_MIN_MHZ = 200;
  localparam int RSCR_MEM_MAX_MHZ = 300;
  localparam int RSCR_LB_MIN_MHZ = 25;
  localparam int RSCR_LB_MAX_MHZ = 133;
  localparam int RSCR_PLAT_MIN_MHZ = 400;
  localparam int RSCR_PLAT_GAP_MHZ = 500;

  // reset values
  localparam logic [7:0] RSCR_DIV_RST = 8'h04;
  localparam logic [1:0] RSCR_SYNC_RST = 2'h0;

  // decoded configuration carrier
  typedef struct packed {
    logic [3:0] plat_mult;
    logic [3:0] core_half;
    logic plat_err;
    logic core_err;
  } rscr_cfg_type;

  // sampling sequence states
  typedef enum logic [1:0] {
    RSCR_ST_WAIT,
    RSCR_ST_SETTLE,
    RSCR_ST_LOCKED
  } rscr_state_type;

endpackage

// >>> hdl/rscr_top.sv
// rscr_top: samples ratio straps at power-up and derives memory and local bus clocks
// assumes straps held steady by the board through reset; one 50 MHz clock drives all
// Contract
// - platform multiplier decoded from four-bit strap
// - core ratio decoded from five-bit strap
// - memory bus clock is half platform
// - local bus clock is platform over divider, with divider values below two taken as two
`timescale 1ns/100ps
module rscr_top
  import rscr_pkg::*;
#(
  parameter int DIV_W = RSCR_DIV_W,
  parameter int SETTLE_CYC = 8
)(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [RSCR_PLAT_W-1:0] platform_ratio_straps_i,
  input wire logic [3:0] core_ratio_strap_upper_i,
  input wire logic core_ratio_strap_lsb_i,
  input wire logic platform_clk_i,
  input wire logic [DIV_W-1:0] local_bus_divider_field_i,
  output logic [3:0] plat_mult_o,
  output logic [3:0] core_half_o,
  output logic cfg_valid_o,
  output logic cfg_error_o,
  output logic mem_bus_clk_o,
  output logic [2:0] local_bus_clock_outputs_o
);

  // reset release synchroniser
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rst_sync_reg <= RSCR_SYNC_RST;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  assign rst_n = rst_sync_reg[1];

  // pin synchronisers: first stage read only by second
  logic [8:0] strap_s1_reg;
  logic [8:0] strap_s2_reg;
  logic plat_s1_reg;
  logic plat_s2_reg;
  logic plat_prev_reg; // edge detect on synced platform clock

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_s1_reg <= '0;
      strap_s2_reg <= '0;
      plat_s1_reg <= 1'b0;
      plat_s2_reg <= 1'b0;
      plat_prev_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      strap_s1_reg <= {platform_ratio_straps_i, core_ratio_strap_upper_i,
                       core_ratio_strap_lsb_i};
      strap_s2_reg <= strap_s1_reg;
      plat_s1_reg <= platform_clk_i;
      plat_s2_reg <= plat_s1_reg;
      plat_prev_reg <= plat_s2_reg;
    end
  end

  // platform multiplier decode, reserved codes flag error
  function automatic logic [4:0] plat_decode(input logic [3:0] code);
    logic [4:0] r;
    r = {4'h0, 1'b1};
    case (code)
      RSCR_PLAT_X2, RSCR_PLAT_X3, RSCR_PLAT_X4, RSCR_PLAT_X5,
      RSCR_PLAT_X6, RSCR_PLAT_X8, RSCR_PLAT_X9:
        r = {code, 1'b0};
      default:
        r = {4'h0, 1'b1};
    endcase
    return r;
  endfunction

  // core ratio decode into half steps
  function automatic logic [4:0] core_decode(input logic [4:0] code);
    logic [4:0] r;
    r = {4'h0, 1'b1};
    case (code)
      RSCR_CORE_2P0: r = {RSCR_HALF_2P0, 1'b0};
      RSCR_CORE_2P5: r = {RSCR_HALF_2P5, 1'b0};
      RSCR_CORE_3P0: r = {RSCR_HALF_3P0, 1'b0};
      RSCR_CORE_3P5: r = {RSCR_HALF_3P5, 1'b0};
      RSCR_CORE_4P0: r = {RSCR_HALF_4P0, 1'b0};
      RSCR_CORE_4P5: r = {RSCR_HALF_4P5, 1'b0};
      default: r = {4'h0, 1'b1};
    endcase
    return r;
  endfunction

  rscr_cfg_type cfg_now; // decode of current synced straps
  logic [4:0] plat_dec;
  logic [4:0] core_dec;

  // straps are not defaulted; a floating strap shows up as an error code
  always_comb
  begin
    plat_dec = plat_decode(strap_s2_reg[8:5]);
    core_dec = core_decode(strap_s2_reg[4:0]);
    cfg_now.plat_mult = plat_dec[4:1];
    cfg_now.core_half = core_dec[4:1];
    cfg_now.plat_err = plat_dec[0];
    cfg_now.core_err = core_dec[0];
  end

  // sampling sequence: let synchronisers fill, then latch once
  rscr_state_type state_reg;
  logic [7:0] settle_reg; // cycles spent settling

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= RSCR_ST_WAIT;
      settle_reg <= '0;
    end
    else if (ce_i)
    begin
      case (state_reg)
        RSCR_ST_WAIT:
          state_reg <= RSCR_ST_SETTLE;
        RSCR_ST_SETTLE:
          if (settle_reg == 8'(SETTLE_CYC - 1))
            state_reg <= RSCR_ST_LOCKED;
          else
            settle_reg <= settle_reg + 8'h01;
        RSCR_ST_LOCKED:
          state_reg <= RSCR_ST_LOCKED; // held until the next reset
        default:
          state_reg <= RSCR_ST_WAIT;
      endcase
    end
  end

  // latched configuration; changes on straps after lock are ignored
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      plat_mult_o <= 4'h0;
      core_half_o <= 4'h0;
      cfg_valid_o <= 1'b0;
      cfg_error_o <= 1'b0;
    end
    else if (ce_i && state_reg == RSCR_ST_SETTLE && settle_reg == 8'(SETTLE_CYC - 1))
    begin
      plat_mult_o <= cfg_now.plat_mult;
      core_half_o <= cfg_now.core_half;
      cfg_valid_o <= ~(cfg_now.plat_err | cfg_now.core_err);
      cfg_error_o <= cfg_now.plat_err | cfg_now.core_err;
    end
  end

  // clocks run only with a good configuration
  logic run;
  logic plat_tick; // one pulse per rising platform edge

  assign run = cfg_valid_o;
  assign plat_tick = plat_s2_reg & ~plat_prev_reg;

  // memory bus clock: fixed divide by two of platform
  logic mem_clk;

  rscr_clkdiv #(
    .W(2)
  ) u_mem_div (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .tick_i(plat_tick),
    .run_i(run),
    .ratio_i(RSCR_MEM_DIV),
    .clk_o(mem_clk)
  );

  // local bus clock: platform over programmed divider, with values below two taken as two
  logic lb_clk;
  logic [DIV_W-1:0] div_reg; // divider taken only at sampled instants

  // divider is sampled each cycle; its source is same-clock logic
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      div_reg <= DIV_W'(RSCR_DIV_RST);
    else if (ce_i)
      div_reg <= local_bus_divider_field_i;
  end

  rscr_clkdiv #(
    .W(DIV_W)
  ) u_lb_div (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .tick_i(plat_tick),
    .run_i(run),
    .ratio_i(div_reg),
    .clk_o(lb_clk)
  );

  // output copies, all three local bus pins in phase
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_bus_clk_o <= 1'b0;
      local_bus_clock_outputs_o <= 3'h0;
    end
    else if (ce_i)
    begin
      mem_bus_clk_o <= mem_clk;
      local_bus_clock_outputs_o <= {3{lb_clk}};
    end
  end

endmodule
